// ===== daq_adc_dac_status_control_tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin bad_count++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, (act), (exp)); end end
module daq_adc_dac_status_control_tb;
  import dasc_pkg::*;
  localparam int DEPTH = 8;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        external_trigger_pin, input_config_pin, ctr0_out, conv_done, scan_last;
  logic        sample_store, sample_take, conv_start, multi_channel_mode, irq, dac_update;
  logic        ctr1_source_select, ctr1_rate_select, ctr0_rate_select, dma_enable;
  logic        timer_irq_req, dio_irq_req, dma_irq_req;
  logic [1:0]  dac_channel_select;
  logic [11:0] dac_code, code;
  logic [7:0]  v;
  logic        sample_accept;
  logic [7:0]  channel_range;
  logic [1:0]  input_gain_select;
  int          n_acc;
  logic [32:0] rdq[$], re;
  logic [13:0] dq[$], de;
  logic [7:0]  thr_in[5] = '{8'h00, 8'h31, 8'hFF, 8'h30, 8'h03};
  logic [7:0]  thr_ex[5] = '{8'h01, 8'h30, 8'h30, 8'h30, 8'h03};
  int          bad_count, n_compared;

  dasc_ctrl #(.FIFO_DEPTH(DEPTH)) i_dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_trigger_pin, .input_config_pin, .ctr0_out, .conv_done, .scan_last, .sample_store,
    .sample_take, .conv_start, .sample_accept, .channel_range, .input_gain_select,
    .multi_channel_mode, .ctr1_source_select, .ctr1_rate_select, .ctr0_rate_select, .dma_enable,
    .timer_irq_req, .dio_irq_req, .dma_irq_req, .irq, .dac_update, .dac_channel_select, .dac_code
  );
  dasc_conv_model i_conv (.clk, .rst, .conv_start, .multi_channel_mode, .conv_done, .scan_last, .sample_store);

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Result watcher: read data and D/A updates against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      re = rdq.pop_front();
      `CHK({pslverr, prdata}, re)
    end
    if (sample_accept === 1'b1) n_acc++;
    if (dac_update === 1'b1) begin
      de = dq.pop_front();
      `CHK({dac_channel_select, dac_code}, de)
    end
  end

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!w) rdq.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b0, idx, 8'h00, {25'h0, d});
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Short pulse on the chosen hardware trigger input
  task automatic kick(input logic ext);
    @(posedge clk);
    if (ext)
      external_trigger_pin <= 1'b1;
    else
      ctr0_out <= 1'b1;
    cyc(3);
    @(posedge clk);
    external_trigger_pin <= 1'b0;
    ctr0_out <= 1'b0;
    cyc(8);
  endtask : kick

  task automatic finish_test();
    bad_count += rdq.size() + dq.size();
    $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    void'($urandom(84));
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {external_trigger_pin, input_config_pin, ctr0_out, sample_take} = 4'b0100;
    {timer_irq_req, dio_irq_req, dma_irq_req} = 3'b000;
    bad_count = 0;
    n_compared = 0;
    n_acc = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(5);
    rd(IDX_CONTROL, 8'h00);
    rd(IDX_THRESHOLD, 8'h01);
    rd(IDX_FIFO_FILL, 8'h00);
    rd(IDX_AN_STATUS, 8'h40);
    apb(1'b0, 10'h001, 8'h00, {1'b1, 32'h0});
    apb(1'b0, IDX_DAC_HIGH, 8'h00, {1'b1, 32'h0});
    @(posedge clk) input_config_pin <= 1'b0;
    cyc(6);
    rd(IDX_AN_STATUS, 8'h00);
    @(posedge clk) input_config_pin <= 1'b1;
    cyc(6);
    // Threshold limits
    foreach (thr_in[i]) begin
      wr(IDX_THRESHOLD, thr_in[i]);
      rd(IDX_THRESHOLD, thr_ex[i]);
    end
    // Random control settings with other interrupt sources
    repeat (6) begin
      v = 8'($urandom()) & 8'hFE;
      @(posedge clk) {timer_irq_req, dio_irq_req, dma_irq_req} <= 3'($urandom());
      wr(IDX_CONTROL, v);
      rd(IDX_CONTROL, v);
      `CHK({ctr1_source_select, ctr1_rate_select, ctr0_rate_select, dma_enable}, {v[7:5], v[3]})
      `CHK(irq, (timer_irq_req & v[2]) | (dio_irq_req & v[1]) | (dma_irq_req & v[3]))
    end
    @(posedge clk) {timer_irq_req, dio_irq_req, dma_irq_req} <= 3'b000;
    // Settling after channel and gain writes
    wr(IDX_CHANNEL, 8'h31);
    `CHK(channel_range, 8'h31)
    rd(IDX_AN_STATUS, 8'h60);
    rd(IDX_CHANNEL, 8'h31);
    wr(IDX_AN_STATUS, 8'h05);
    `CHK({multi_channel_mode, input_gain_select}, 3'h5)
    cyc(215);
    rd(IDX_AN_STATUS, 8'h65);
    cyc(10);
    rd(IDX_AN_STATUS, 8'h45);
    // D/A update on every channel, low byte first
    for (int ch = 0; ch < 4; ch++) begin
      code = 12'($urandom());
      wr(IDX_DAC_LOW, code[7:0]);
      dq.push_back({2'(ch), code});
      wr(IDX_DAC_HIGH, {2'(ch), 2'b11, code[11:8]});
      rd(IDX_AN_STATUS, 8'h45 | 8'h10);
      cyc(738);
      rd(IDX_AN_STATUS, 8'h55);
      cyc(10);
      rd(IDX_AN_STATUS, 8'h45);
    end
    // Software single conversion, then a scan
    wr(IDX_AN_STATUS, 8'h01);
    cyc(230);
    wr(IDX_COMMAND, 8'h01);
    rd(IDX_AN_STATUS, 8'hC1);
    cyc(20);
    rd(IDX_AN_STATUS, 8'h41);
    rd(IDX_FIFO_FILL, 8'h01);
    wr(IDX_AN_STATUS, 8'h05);
    cyc(230);
    wr(IDX_COMMAND, 8'h01);
    cyc(30);
    rd(IDX_AN_STATUS, 8'hC5);
    cyc(25);
    rd(IDX_AN_STATUS, 8'h45);
    rd(IDX_FIFO_FILL, 8'h04);
    // Hardware triggers, threshold request, clear and gating
    wr(IDX_COMMAND, 8'h06);
    rd(IDX_FIFO_FILL, 8'h00);
    wr(IDX_CONTROL, 8'h11);
    wr(IDX_COMMAND, 8'h01);
    rd(IDX_AN_STATUS, 8'h45);
    kick(1'b0);
    rd(IDX_AN_STATUS, 8'h45);
    kick(1'b1);
    rd(IDX_AN_STATUS, 8'hC5);
    cyc(50);
    `CHK(irq, 1'b1)
    rd(IDX_FIFO_FILL, 8'h03);
    @(posedge clk) sample_take <= 1'b1;
    @(posedge clk) sample_take <= 1'b0;
    cyc(2);
    rd(IDX_FIFO_FILL, 8'h02);
    `CHK(irq, 1'b1)
    wr(IDX_CONTROL, 8'h10);
    `CHK(irq, 1'b0)
    wr(IDX_CONTROL, 8'h01);
    `CHK(irq, 1'b1)
    wr(IDX_COMMAND, 8'h04);
    `CHK(irq, 1'b0)
    kick(1'b0);
    rd(IDX_AN_STATUS, 8'hC5);
    cyc(50);
    `CHK(irq, 1'b1)
    rd(IDX_FIFO_FILL, 8'h05);
    // Fill to the limit, then one more scan overruns
    wr(IDX_COMMAND, 8'h04);
    kick(1'b0);
    cyc(50);
    rd(IDX_AN_STATUS, 8'h45);
    kick(1'b0);
    cyc(50);
    rd(IDX_AN_STATUS, 8'h4D);
    rd(IDX_FIFO_FILL, 8'(DEPTH));
    wr(IDX_COMMAND, 8'h02);
    rd(IDX_AN_STATUS, 8'h45);
    rd(IDX_FIFO_FILL, 8'h00);
    cyc(3);
    `CHK(n_acc, 32'h0000_000D)
    finish_test();
  end
endmodule : daq_adc_dac_status_control_tb

// ===== dasc_conv_model.sv
// Behavioural converter core that answers start requests with conversions
`timescale 1ns/1ps
module dasc_conv_model #(
  parameter int LAT = 12
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Requests from the control block
  input  wire logic conv_start,
  input  wire logic multi_channel_mode,
  // Results back to the control block
  output logic      conv_done,
  output logic      scan_last,
  output logic      sample_store
);
  int   cnt_reg;
  int   left_reg;
  logic mm_reg;
  // One conversion takes LAT to LAT+3 cycles; a scan is three conversions
  always @(posedge clk) begin
    conv_done <= 1'b0;
    scan_last <= 1'b0;
    sample_store <= 1'b0;
    if (rst) begin
      left_reg <= 0;
    end else if (left_reg == 0) begin
      if (conv_start) begin
        left_reg <= multi_channel_mode ? 3 : 1;
        mm_reg <= multi_channel_mode;
        cnt_reg <= LAT;
      end
    end else if (cnt_reg > 1) begin
      cnt_reg <= cnt_reg - 1;
    end else begin
      conv_done <= 1'b1;
      sample_store <= 1'b1;
      scan_last <= mm_reg && (left_reg == 1);
      left_reg <= left_reg - 1;
      cnt_reg <= LAT + $urandom_range(0, 3);
    end
  end
endmodule : dasc_conv_model

// ===== dasc_ctrl.sv
// Converter control and status block with APB register access
// Function
// - Status bit 7 shows conversion or scan in progress.
// - Single mode: active per conversion; multi-channel mode: active for whole scan.
// - Status bit 6 reads 1 single-ended, 0 differential.
// - Channel or gain write holds settling bit 5 high for 9 us.
// - Bit 4 dac_busy high during D/A update, about 30 us.
// - Store into full FIFO sets sticky overrun, refuses samples until flush.
// - Status bit 2 returns multi-channel mode, bits 1-0 gain.
// - Control bit 7 picks counter 1 internal or external clock.
// - Control bit 6 picks counter 1 internal rate 10MHz or 100KHz.
// - Control bit 5 picks counter 0 rate 10MHz or 1MHz.
// - With analog interrupts on, bit 4 picks counter 0 or external trigger.
// - Control bits 3..0 enable DMA, timer, digital, analog interrupts.
// - Analog interrupts on: software start ignored, hardware trigger starts.
// - All enabled interrupt sources share one request line.
// - FIFO count reaching threshold sets analog_irq_pending.
// - Threshold acts within 1 to 48.
// - Offset 6 read returns fill count, bits 7-6 zero.
// - 12-bit D/A code; high byte write updates using stored low byte.
// - High byte carries channel in 7-6 and code bits 11-8.
// - Writing analog_irq_clear resets the analog request flip-flop.
// - FIFO flush sets fill count to zero.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module dasc_ctrl #(
  parameter int FIFO_DEPTH = 48
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        external_trigger_pin,
  input  wire logic        input_config_pin,
  // Converter core
  input  wire logic        ctr0_out,
  input  wire logic        conv_done,
  input  wire logic        scan_last,
  input  wire logic        sample_store,
  input  wire logic        sample_take,
  output logic             conv_start,
  output logic             sample_accept,
  output logic      [7:0]  channel_range,
  output logic      [1:0]  input_gain_select,
  output logic             multi_channel_mode,
  // Counter and DMA selects
  output logic             ctr1_source_select,
  output logic             ctr1_rate_select,
  output logic             ctr0_rate_select,
  output logic             dma_enable,
  // Other interrupt requests and shared line
  input  wire logic        timer_irq_req,
  input  wire logic        dio_irq_req,
  input  wire logic        dma_irq_req,
  output logic             irq,
  // D/A serial engine
  output logic             dac_update,
  output logic      [1:0]  dac_channel_select,
  output logic      [11:0] dac_code
);
  import dasc_pkg::*;

  localparam logic [9:0] SETTLE_N = 10'(SETTLE_CYCLES);
  localparam logic [9:0] DACB_N   = 10'(DAC_BUSY_CYCLES);
  localparam logic [5:0] DEPTH_N  = 6'(FIFO_DEPTH);

  dasc_conv_state_t state_reg;
  logic [7:0] control_reg;
  logic [5:0] threshold_reg;
  logic [7:0] dac_low_bits_reg;
  logic [5:0] fifo_fill_count_reg;
  logic       fifo_overrun_flag_reg;
  logic       analog_irq_pending_reg;
  logic [9:0] settle_cnt_reg;
  logic [9:0] dac_cnt_reg;
  logic [2:0] trig_sync_reg;
  logic [2:0] cfg_sync_reg;
  logic       trig_lvl_reg;
  logic       input_config_flag_reg;
  logic       trig_prev_reg;
  logic       ctr0_prev_reg;

  logic       wr;
  logic       rd;
  logic [9:0] idx;
  logic       mapped;
  logic       cmd_wr;
  logic       sw_start;
  logic       flush;
  logic       irq_clear;
  logic       hw_trig;
  logic       start_req;
  logic       store_ok;
  logic       settling;
  logic       dac_busy;
  logic       analog_irq_enable;
  logic [5:0] thr_eff;
  logic [5:0] fill_next;
  logic [7:0] status;

  // APB decode; single-cycle access
  assign idx     = paddr[11:2];
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign cmd_wr  = wr & (idx == IDX_COMMAND);
  assign sw_start  = cmd_wr & pwdata[CMD_SW_START];
  assign flush     = cmd_wr & pwdata[CMD_FLUSH];
  assign irq_clear = cmd_wr & pwdata[CMD_IRQ_CLEAR];

  // Map check per direction
  always_comb begin
    if (pwrite) begin
      mapped = (idx == IDX_COMMAND) || (idx >= IDX_CHANNEL && idx <= IDX_DAC_HIGH);
    end else begin
      mapped = (idx >= IDX_CHANNEL && idx <= IDX_FIFO_FILL);
    end
  end
  assign pslverr = psel & penable & ~mapped;

  // Control register fields
  assign analog_irq_enable  = control_reg[CT_ANALOG_EN];
  assign ctr1_source_select = control_reg[CT_CTR1_SRC];
  assign ctr1_rate_select   = control_reg[CT_CTR1_RATE];
  assign ctr0_rate_select   = control_reg[CT_CTR0_RATE];
  assign dma_enable         = control_reg[CT_DMA_EN];

  // Writable configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      control_reg        <= CONTROL_RST;
      channel_range      <= CHANNEL_RST;
      multi_channel_mode <= 1'b0;
      input_gain_select  <= 2'h0;
    end else if (wr) begin
      case (idx)
        IDX_CONTROL:   control_reg <= pwdata[7:0];
        IDX_CHANNEL:   channel_range <= pwdata[7:0];
        IDX_AN_STATUS: begin
          multi_channel_mode <= pwdata[ST_MULTI_CH];
          input_gain_select  <= pwdata[1:0];
        end
        default: ;
      endcase
    end
  end

  // Threshold stored clamped to 1..48
  always_ff @(posedge clk) begin
    if (rst) begin
      threshold_reg <= THRESHOLD_RST;
    end else if (wr && idx == IDX_THRESHOLD) begin
      if (pwdata[5:0] > THR_MAX) begin
        threshold_reg <= THR_MAX;
      end else if (pwdata[5:0] == 6'h00) begin
        threshold_reg <= THR_MIN;
      end else begin
        threshold_reg <= pwdata[5:0];
      end
    end
  end
  assign thr_eff = threshold_reg;

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_sync_reg         <= 3'h0;
      cfg_sync_reg          <= 3'h0;
      trig_lvl_reg          <= 1'b0;
      input_config_flag_reg <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], external_trigger_pin};
      cfg_sync_reg  <= {cfg_sync_reg[1:0], input_config_pin};
      if (trig_sync_reg[1] == trig_sync_reg[2]) begin
        trig_lvl_reg <= trig_sync_reg[2];
      end
      if (cfg_sync_reg[1] == cfg_sync_reg[2]) begin
        input_config_flag_reg <= cfg_sync_reg[2];
      end
    end
  end

  // Trigger edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev_reg <= 1'b0;
      ctr0_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_lvl_reg;
      ctr0_prev_reg <= ctr0_out;
    end
  end

  // Start source: hardware when analog interrupts on, else software
  assign hw_trig = control_reg[CT_TRIG_SRC] ? (trig_lvl_reg & ~trig_prev_reg)
                                            : (ctr0_out & ~ctr0_prev_reg);
  assign start_req  = analog_irq_enable ? hw_trig : sw_start;
  assign conv_start = start_req && (state_reg == CS_IDLE);

  // Conversion activity state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= CS_IDLE;
    end else begin
      case (state_reg)
        CS_IDLE: if (conv_start) state_reg <= CS_BUSY;
        CS_BUSY: if (conv_done && (!multi_channel_mode || scan_last)) state_reg <= CS_IDLE;
        default: state_reg <= CS_IDLE;
      endcase
    end
  end

  // Settling timer restarted by channel or gain writes
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_cnt_reg <= 10'h000;
    end else if (wr && (idx == IDX_CHANNEL || idx == IDX_AN_STATUS)) begin
      settle_cnt_reg <= SETTLE_N;
    end else if (settle_cnt_reg != 10'h000) begin
      settle_cnt_reg <= settle_cnt_reg - 10'h001;
    end
  end
  assign settling = (settle_cnt_reg != 10'h000);

  // FIFO fill count, overrun and acceptance
  assign store_ok      = sample_store && !fifo_overrun_flag_reg && (fifo_fill_count_reg < DEPTH_N);
  assign sample_accept = store_ok;
  always_comb begin
    fill_next = fifo_fill_count_reg;
    if (store_ok && !(sample_take && fifo_fill_count_reg != 6'h00)) begin
      fill_next = fifo_fill_count_reg + 6'h01;
    end else if (!store_ok && sample_take && fifo_fill_count_reg != 6'h00) begin
      fill_next = fifo_fill_count_reg - 6'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      fifo_fill_count_reg <= 6'h00;
    end else begin
      fifo_fill_count_reg <= fill_next;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      fifo_overrun_flag_reg <= 1'b0;
    end else if (sample_store && fifo_fill_count_reg >= DEPTH_N) begin
      fifo_overrun_flag_reg <= 1'b1;
    end
  end

  // Analog request: latched, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_irq_pending_reg <= 1'b0;
    end else if (store_ok && fill_next == thr_eff) begin
      analog_irq_pending_reg <= 1'b1;
    end else if (irq_clear) begin
      analog_irq_pending_reg <= 1'b0;
    end
  end

  // Shared interrupt line
  assign irq = (analog_irq_pending_reg & analog_irq_enable)
             | (timer_irq_req & control_reg[CT_TIMER_EN])
             | (dio_irq_req & control_reg[CT_DIO_EN])
             | (dma_irq_req & control_reg[CT_DMA_EN]);

  // D/A low byte holding register
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_low_bits_reg <= 8'h00;
    end else if (wr && idx == IDX_DAC_LOW) begin
      dac_low_bits_reg <= pwdata[7:0];
    end
  end

  // D/A update launched by high byte write
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_update         <= 1'b0;
      dac_channel_select <= 2'h0;
      dac_code           <= 12'h000;
      dac_cnt_reg        <= 10'h000;
    end else begin
      dac_update <= 1'b0;
      if (wr && idx == IDX_DAC_HIGH) begin
        dac_update         <= 1'b1;
        dac_channel_select <= pwdata[DH_CH_LSB+1:DH_CH_LSB];
        dac_code           <= {pwdata[3:0], dac_low_bits_reg};
        dac_cnt_reg        <= DACB_N;
      end else if (dac_cnt_reg != 10'h000) begin
        dac_cnt_reg <= dac_cnt_reg - 10'h001;
      end
    end
  end
  assign dac_busy = (dac_cnt_reg != 10'h000);

  // Status byte
  assign status = {state_reg == CS_BUSY, input_config_flag_reg, settling, dac_busy,
                   fifo_overrun_flag_reg, multi_channel_mode, input_gain_select};

  // Read data
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (idx)
        IDX_CHANNEL:   prdata[7:0] = channel_range;
        IDX_AN_STATUS: prdata[7:0] = status;
        IDX_CONTROL:   prdata[7:0] = control_reg;
        IDX_THRESHOLD: prdata[5:0] = threshold_reg;
        IDX_FIFO_FILL: prdata[5:0] = fifo_fill_count_reg;
        default:       prdata = 32'h0000_0000;
      endcase
    end
  end

  // Cycles since the last channel or gain write, saturating; watched by the settling checks
  logic [9:0] settle_age_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_age_reg <= 10'h3FF;
    end else if (wr && (idx == IDX_CHANNEL || idx == IDX_AN_STATUS)) begin
      settle_age_reg <= 10'h001;
    end else if (settle_age_reg != 10'h3FF) begin
      settle_age_reg <= settle_age_reg + 10'h001;
    end
  end

  // Sequences used by checks
  sequence s_ctrl_wr;
    wr && (idx == IDX_CHANNEL || idx == IDX_AN_STATUS);
  endsequence
  sequence s_dac_wr;
    wr && idx == IDX_DAC_HIGH;
  endsequence

  a_settle_start: assert property (@(posedge clk) disable iff (rst)
    s_ctrl_wr |=> settling && settle_cnt_reg == SETTLE_N) else $error("settling not started");
  a_settle_hold: assert property (@(posedge clk) disable iff (rst)
    settle_age_reg <= SETTLE_N |-> settling) else $error("settling not held");
  a_settle_end: assert property (@(posedge clk) disable iff (rst)
    settle_age_reg > SETTLE_N |-> !settling) else $error("settling did not end");
  a_dac_busy_run: assert property (@(posedge clk) disable iff (rst)
    s_dac_wr |=> dac_busy && dac_update && dac_code[7:0] == $past(dac_low_bits_reg)) else $error("dac update wrong");
  a_dac_busy_len: assert property (@(posedge clk) disable iff (rst)
    $fell(dac_busy) |-> $past(dac_cnt_reg) == 10'h001) else $error("dac busy length wrong");
  a_overrun_sticky: assert property (@(posedge clk) disable iff (rst)
    fifo_overrun_flag_reg && !flush |=> fifo_overrun_flag_reg && !sample_accept) else $error("overrun lost");
  a_overrun_set: assert property (@(posedge clk) disable iff (rst)
    sample_store && fifo_fill_count_reg == DEPTH_N && !flush |=> fifo_overrun_flag_reg) else $error("overrun not set");
  a_flush_zero: assert property (@(posedge clk) disable iff (rst)
    flush |=> fifo_fill_count_reg == 6'h00 && !fifo_overrun_flag_reg) else $error("flush failed");
  a_thr_range: assert property (@(posedge clk) disable iff (rst)
    threshold_reg >= THR_MIN && threshold_reg <= THR_MAX) else $error("threshold out of range");
  a_sw_ignored: assert property (@(posedge clk) disable iff (rst)
    analog_irq_enable && !hw_trig |-> !conv_start) else $error("software start not ignored");
  a_pend_latch: assert property (@(posedge clk) disable iff (rst)
    analog_irq_pending_reg && !irq_clear |=> analog_irq_pending_reg) else $error("request dropped");
  a_irq_analog: assert property (@(posedge clk) disable iff (rst)
    analog_irq_pending_reg && analog_irq_enable |-> irq) else $error("line not raised");
  a_pend_set: assert property (@(posedge clk) disable iff (rst)
    store_ok && fill_next == thr_eff |=> analog_irq_pending_reg) else $error("threshold request missed");
  a_single_end: assert property (@(posedge clk) disable iff (rst)
    state_reg == CS_BUSY && conv_done && !multi_channel_mode |=> state_reg == CS_IDLE) else $error("single not ended");
  a_scan_hold: assert property (@(posedge clk) disable iff (rst)
    state_reg == CS_BUSY && conv_done && multi_channel_mode && !scan_last |=> status[ST_CONV_ACTIVE])
    else $error("scan ended early");
endmodule : dasc_ctrl

// ===== dasc_pkg.sv
// Package: register map, field positions and timing counts of the converter control block
package dasc_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_COMMAND   = 10'h000;
  localparam logic [9:0] IDX_CHANNEL   = 10'h002;
  localparam logic [9:0] IDX_AN_STATUS = 10'h003;
  localparam logic [9:0] IDX_CONTROL   = 10'h004;
  localparam logic [9:0] IDX_THRESHOLD = 10'h005;
  localparam logic [9:0] IDX_DAC_LOW   = 10'h006;
  localparam logic [9:0] IDX_FIFO_FILL = 10'h006;
  localparam logic [9:0] IDX_DAC_HIGH  = 10'h007;
  // Command register bits
  localparam int CMD_SW_START  = 0;
  localparam int CMD_FLUSH     = 1;
  localparam int CMD_IRQ_CLEAR = 2;
  // Analog status bits
  localparam int ST_CONV_ACTIVE = 7;
  localparam int ST_INPUT_CFG   = 6;
  localparam int ST_SETTLING    = 5;
  localparam int ST_DAC_BUSY    = 4;
  localparam int ST_OVERRUN     = 3;
  localparam int ST_MULTI_CH    = 2;
  // Control register bits
  localparam int CT_CTR1_SRC  = 7;
  localparam int CT_CTR1_RATE = 6;
  localparam int CT_CTR0_RATE = 5;
  localparam int CT_TRIG_SRC  = 4;
  localparam int CT_DMA_EN    = 3;
  localparam int CT_TIMER_EN  = 2;
  localparam int CT_DIO_EN    = 1;
  localparam int CT_ANALOG_EN = 0;
  // DAC high byte fields
  localparam int DH_CH_LSB = 6;
  // Reset values
  localparam logic [7:0] CONTROL_RST   = 8'h00;
  localparam logic [7:0] CHANNEL_RST   = 8'h00;
  localparam logic [5:0] THRESHOLD_RST = 6'h01;
  // Threshold limits
  localparam logic [5:0] THR_MIN = 6'h01;
  localparam logic [5:0] THR_MAX = 6'h30;
  // Timing
  localparam int CLK_MHZ         = 25;
  localparam int SETTLE_US       = 9;
  localparam int DAC_BUSY_US     = 30;
  localparam int SETTLE_CYCLES   = SETTLE_US * CLK_MHZ;
  localparam int DAC_BUSY_CYCLES = DAC_BUSY_US * CLK_MHZ;
  // Converter control states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_BUSY = 2'b10
  } dasc_conv_state_t;
endpackage : dasc_pkg
